/* File: rtl/dmsd_monitor_top.sv */
// demodulator monitor path: offset removal, gain and a second-order sigma-delta modulator
// assumes demodulator samples arrive on the core clock and a classic wishbone master
// What this block does
// RULE_01: enabled monitor turns 16-bit post-filter output into one-bit second-order sigma-delta stream.
// RULE_02: the modulator bit drives the clock output pin for external filtering.
// RULE_03: samples move on demodulator clock ticks; modulator steps on data-recovery ticks.
// RULE_04: data recovery stops when its clock is at or above demodulator clock.
// RULE_05: controller may raise data-recovery clock for better monitor quality.
// RULE_06: digital test mode 7 enables the monitor without offset subtraction.
// RULE_07: digital test mode 10 enables the monitor with offset subtraction.
// RULE_08: modulator input comes from whichever demodulator is active.
// RULE_09: controller programs the offset near the intermediate frequency for linear demodulation.
// RULE_10: controller writes half the measured intermediate frequency into the offset field.
// RULE_11: modulator input is (signal minus offset/4096) times two to the gain.
// RULE_12: integral coefficient resets to 3, proportional coefficient to 2.
// RULE_13: test register resets to 0x0000000C, monitor disabled.
// RULE_14: offset and gain writes only land when select bits carry its code.
`timescale 1ns/1ps
module dmsd_monitor_top #(
	parameter int FIFO_DEPTH = 16,
	parameter int SAMPLE_W = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	// demodulator outputs
	input wire logic i_linear_active,
	input wire logic [SAMPLE_W-1:0] i_corr_sample,
	input wire logic [SAMPLE_W-1:0] i_lin_sample,
	input wire logic i_sample_valid,
	output logic o_sample_ready,
	// pin and status
	output logic o_clock_output_pin,
	output logic o_cdr_run
);
	localparam logic [23:0] FB_POS = 24'h007FFF;
	localparam logic [23:0] FB_NEG = 24'hFF8000;

	logic [31:0] test_q;
	logic [31:0] og_q;
	logic [15:0] div_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic req;
	logic wr_en;
	dmsd_pkg::dmsd_mode_t mode;
	logic mon_en;
	logic [7:0] demod_cnt_q;
	logic [7:0] cdr_cnt_q;
	logic demod_tick_q;
	logic cdr_tick_q;
	logic cdr_run_q;
	logic [SAMPLE_W-1:0] src_sample;
	logic fifo_valid;
	logic [SAMPLE_W-1:0] fifo_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_count;
	logic fifo_push_ok;
	logic pop;
	logic [SAMPLE_W-1:0] dac_in_d;
	logic [SAMPLE_W-1:0] dac_in_q;
	logic [23:0] int1_q;
	logic [23:0] int2_q;
	logic [23:0] int1_d;
	logic [23:0] int2_d;
	logic bit_q;
	logic pin_q;

	// saturate a wide signed value into 16 bits
	function automatic logic [15:0] sat16(input logic signed [35:0] v);
		if (v > 36'sd32767) begin
			sat16 = 16'h7FFF;
		end else if (v < -36'sd32768) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// saturating integrator add; keeps the loop from wrapping on full-scale input
	function automatic logic [23:0] sat_add24(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
		logic signed [25:0] s;
		s = 26'(signed'(a)) + 26'(signed'(b)) - 26'(signed'(c));
		if (s > 26'sh7FFFFF) begin
			sat_add24 = 24'h7FFFFF;
		end else if (s < -26'sh800000) begin
			sat_add24 = 24'h800000;
		end else begin
			sat_add24 = s[23:0];
		end
	endfunction

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		merge = r;
	endfunction

	// bus request; the write lands on the edge where the master sees ack
	assign req = i_wb_cyc && i_wb_stb;
	assign wr_en = req && i_wb_we && ack_q;

	// ack one cycle after the request, for one cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	// read data; offset and gain register is write-only, unmapped reads give zero
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rdat_q <= 32'h00000000;
		end else if (req && !ack_q && !i_wb_we) begin
			case (i_wb_adr)
				dmsd_pkg::ADDR_TEST: rdat_q <= test_q;
				dmsd_pkg::ADDR_CLK_DIV: rdat_q <= {16'h0000, div_q};
				dmsd_pkg::ADDR_STATUS: rdat_q <= {24'h000000, 3'(fifo_count), cdr_run_q, bit_q, mon_en, 2'(mode)};
				default: rdat_q <= 32'h00000000;
			endcase
		end
	end

	// test register
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			test_q <= dmsd_pkg::TEST_RESET; // RULE_13
		end else if (wr_en && i_wb_adr == dmsd_pkg::ADDR_TEST) begin
			test_q <= merge(test_q, i_wb_dat, i_wb_sel);
		end
	end

	// offset and gain register; words with a foreign select code are dropped
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			og_q <= dmsd_pkg::OFS_GAIN_RESET; // RULE_12
		end else if (wr_en && i_wb_adr == dmsd_pkg::ADDR_OFS_GAIN
			&& i_wb_dat[dmsd_pkg::SEL_W-1:0] == dmsd_pkg::OFS_GAIN_SELECT && i_wb_sel[0]) begin // RULE_14
			og_q <= merge(og_q, i_wb_dat, i_wb_sel);
		end
	end

	// clock divider register: demodulator divide in [7:0], data-recovery divide in [15:8]
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			div_q <= {dmsd_pkg::CDR_DIV_RESET, dmsd_pkg::DEMOD_DIV_RESET};
		end else if (wr_en && i_wb_adr == dmsd_pkg::ADDR_CLK_DIV) begin
			div_q <= 16'(merge({16'h0000, div_q}, i_wb_dat, i_wb_sel));
		end
	end

	// test mode decode
	always_comb begin
		case (test_q[dmsd_pkg::TMODE_LSB +: dmsd_pkg::TMODE_W])
			dmsd_pkg::TMODE_MON_RAW: mode = dmsd_pkg::MON_RAW; // RULE_06
			dmsd_pkg::TMODE_MON_OFS: mode = dmsd_pkg::MON_OFFSET; // RULE_07
			default: mode = dmsd_pkg::MON_OFF;
		endcase
	end
	assign mon_en = (mode != dmsd_pkg::MON_OFF);

	// internal clock rates as ticks of the core clock; a divide of zero acts as one
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			demod_cnt_q <= 8'h00;
			demod_tick_q <= 1'b0;
		end else if (demod_cnt_q == 8'h00) begin
			demod_cnt_q <= (div_q[7:0] == 8'h00) ? 8'h00 : div_q[7:0] - 8'h01;
			demod_tick_q <= 1'b1;
		end else begin
			demod_cnt_q <= demod_cnt_q - 8'h01;
			demod_tick_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cdr_cnt_q <= 8'h00;
			cdr_tick_q <= 1'b0;
		end else if (cdr_cnt_q == 8'h00) begin
			cdr_cnt_q <= (div_q[15:8] == 8'h00) ? 8'h00 : div_q[15:8] - 8'h01;
			cdr_tick_q <= 1'b1;
		end else begin
			cdr_cnt_q <= cdr_cnt_q - 8'h01;
			cdr_tick_q <= 1'b0;
		end
	end

	// data recovery runs only while its clock is slower than the demodulator clock
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cdr_run_q <= 1'b0;
		end else begin
			cdr_run_q <= (div_q[15:8] > div_q[7:0]); // RULE_04
		end
	end

	// source select follows the active demodulator
	assign src_sample = i_linear_active ? i_lin_sample : i_corr_sample; // RULE_08
	assign fifo_push_ok = i_sample_valid && demod_tick_q; // RULE_03

	// the fifo absorbs the rate gap between the two ticks; flushed while the monitor is off
	dmsd_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_flush(!mon_en),
		.i_valid(fifo_push_ok),
		.i_data(src_sample),
		.o_ready(o_sample_ready),
		.o_valid(fifo_valid),
		.o_data(fifo_data),
		.i_ready(cdr_tick_q),
		.o_count(fifo_count)
	);
	assign pop = fifo_valid && cdr_tick_q && mon_en; // RULE_03

	// offset removal and power-of-two gain; gain above 15 is clamped
	always_comb begin
		logic signed [35:0] diff;
		logic [4:0] g;
		diff = 36'(signed'(fifo_data));
		g = og_q[dmsd_pkg::GAIN_LSB +: dmsd_pkg::GAIN_W];
		if (g > dmsd_pkg::GAIN_MAX) begin
			g = dmsd_pkg::GAIN_MAX;
		end
		if (mode == dmsd_pkg::MON_OFFSET) begin
			diff = diff - (36'(og_q[dmsd_pkg::OFS_LSB +: dmsd_pkg::OFS_W]) << dmsd_pkg::OFS_UNIT_SHIFT); // RULE_11
		end
		dac_in_d = sat16(diff <<< g); // RULE_11
	end

	// modulator input holds between pops
	always_ff @(posedge i_core_clk) begin
		if (i_srst || !mon_en) begin
			dac_in_q <= 16'h0000;
		end else if (pop) begin
			dac_in_q <= dac_in_d;
		end
	end

	// two cascaded integrators, each fed back from the one-bit output
	always_comb begin
		int1_d = sat_add24(int1_q, 24'(signed'(dac_in_q)), bit_q ? FB_POS : FB_NEG);
		int2_d = sat_add24(int2_q, int1_d, bit_q ? FB_POS : FB_NEG);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst || !mon_en) begin
			int1_q <= 24'h000000;
			int2_q <= 24'h000000;
			bit_q <= 1'b0;
		end else if (cdr_tick_q) begin
			int1_q <= int1_d; // RULE_01
			int2_q <= int2_d;
			bit_q <= !int2_d[23]; // RULE_01
		end
	end

	// pin shows the bit stream only while monitoring, else stays low
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= mon_en && bit_q; // RULE_02
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_clock_output_pin = pin_q;
	assign o_cdr_run = cdr_run_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_write(logic [3:0] a, logic [31:0] d);
		req && i_wb_we && ack_q && i_wb_adr == a && i_wb_dat == d && i_wb_sel == 4'hF;
	endsequence

	sequence s_step;
		mon_en && cdr_tick_q ##1 mon_en;
	endsequence

	a_pin_follows_bit: assert property (mon_en && !$past(i_srst) |=> pin_q == $past(bit_q)) // RULE_02
		else $error("pin does not follow modulator bit");
	a_pin_low_off: assert property (!mon_en |=> !pin_q) // RULE_02
		else $error("pin active while monitor off");
	a_cdr_stop_fast: assert property (div_q[15:8] <= div_q[7:0] |=> !o_cdr_run) // RULE_04
		else $error("data recovery runs at too fast a clock");
	a_test_reset_val: assert property ($past(i_srst) |-> test_q == 32'h0000000C && !mon_en) // RULE_13
		else $error("test register reset wrong");
	a_coef_reset: assert property ($past(i_srst) |-> // RULE_12
		og_q[dmsd_pkg::KP_LSB +: dmsd_pkg::KP_W] == dmsd_pkg::KP_RESET
		&& og_q[dmsd_pkg::KI_LSB +: dmsd_pkg::KI_W] == dmsd_pkg::KI_RESET)
		else $error("coefficient defaults wrong");
	a_sel_guard: assert property (wr_en && i_wb_adr == 4'h4 && i_wb_dat[3:0] != 4'hD |=> $stable(og_q)) // RULE_14
		else $error("offset register took foreign select code");
	a_mode7_raw: assert property (s_write(4'h0, 32'h0001C00C) |=> mode == dmsd_pkg::MON_RAW ##1 mon_en) // RULE_06
		else $error("test mode 7 did not enable monitor");
	a_mode10_ofs: assert property (s_write(4'h0, 32'h0002800C) |=> mode == dmsd_pkg::MON_OFFSET) // RULE_07
		else $error("test mode 10 did not enable offset monitor");
	a_pop_on_cdr: assert property (pop |-> cdr_tick_q && $past(cdr_cnt_q) == 8'h00) // RULE_03
		else $error("sample taken off the data-recovery tick");
	a_raw_unity: assert property (pop && mode == dmsd_pkg::MON_RAW && og_q[31:27] == 5'h00 |=> dac_in_q == $past(fifo_data)) // RULE_11
		else $error("raw mode altered the sample");
	a_bit_sign: assert property (s_step |-> ##0 1'b1 ##0 bit_q == !$past(int2_d[23])) // RULE_01
		else $error("modulator bit does not match second integrator");
	a_ack_pulse: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
endmodule

/* File: pkg/dmsd_pkg.sv */
// constants for the demodulator monitor sigma-delta path: register map, fields, resets
// assumes a 32-bit classic wishbone register bus and a 100 MHz core clock
package dmsd_pkg;
	// register byte offsets
	localparam logic [3:0] ADDR_TEST = 4'h0;
	localparam logic [3:0] ADDR_OFS_GAIN = 4'h4;
	localparam logic [3:0] ADDR_CLK_DIV = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	// reset values
	localparam logic [31:0] TEST_RESET = 32'h0000000C;
	localparam logic [3:0] OFS_GAIN_SELECT = 4'hD;
	// select code 0xD, proportional coefficient 2 in [6:4], integral coefficient 3 in [10:7]
	localparam logic [31:0] OFS_GAIN_RESET = 32'h000001AD;
	localparam logic [7:0] DEMOD_DIV_RESET = 8'h08;
	localparam logic [7:0] CDR_DIV_RESET = 8'h10;
	// test register: digital test mode field
	localparam int TMODE_LSB = 14;
	localparam int TMODE_W = 5;
	localparam logic [4:0] TMODE_MON_RAW = 5'h07;
	localparam logic [4:0] TMODE_MON_OFS = 5'h0A;
	// offset and gain register fields
	localparam int SEL_W = 4;
	localparam int KP_LSB = 4;
	localparam int KP_W = 3;
	localparam int KI_LSB = 7;
	localparam int KI_W = 4;
	localparam int PE_LSB = 12;
	localparam int PE_W = 4;
	localparam int OFS_LSB = 16;
	localparam int OFS_W = 11;
	localparam int GAIN_LSB = 27;
	localparam int GAIN_W = 5;
	localparam logic [2:0] KP_RESET = 3'h2;
	localparam logic [3:0] KI_RESET = 4'h3;
	// offset of 4096 equals full scale 1.0, i.e. 32768 sample units
	localparam int OFS_UNIT_SHIFT = 3;
	localparam logic [4:0] GAIN_MAX = 5'h0F;
	// monitor mode
	typedef enum logic [1:0] {MON_OFF, MON_RAW, MON_OFFSET} dmsd_mode_t;
endpackage

/* File: rtl/dmsd_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush input
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dmsd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_flush,
	// fill side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// drain side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready,
	// fill level
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic ready_q;
	logic push;
	logic pop;

	// handshakes; both sides are honest about full and empty
	assign push = i_valid && ready_q && !i_flush;
	assign pop = i_ready && (count_q != '0) && !i_flush;
	assign o_valid = (count_q != '0);
	assign o_data = mem_q[rd_ptr_q];
	assign o_ready = ready_q;
	assign o_count = count_q;

	// next fill level
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	// storage
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_data;
		end
	end

	// pointers, level and registered ready
	always_ff @(posedge i_core_clk) begin
		if (i_srst || i_flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			ready_q <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			ready_q <= (count_d != FULL);
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	a_fifo_no_overrun: assert property (count_q == FULL |-> !o_ready)
		else $error("fifo shows ready while full");
endmodule

/* File: tb/dmsd_rc_meter.sv */
// stand-in for the external rc filter and meter on the clock output pin
// assumes the pin is sampled on the core clock; a clear restarts a window
`timescale 1ns/1ps
module dmsd_rc_meter (
	// clock and window control
	input wire logic i_core_clk,
	input wire logic i_clear,
	// pin under observation
	input wire logic i_pin,
	// results
	output logic [15:0] o_ones,
	output logic [15:0] o_min_gap
);
	logic last_q;
	logic seen_q;
	logic [15:0] gap_q;
	// the count of ones is the filtered average level of the pin
	always_ff @(posedge i_core_clk) begin
		if (i_clear) begin
			o_ones <= 16'h0000;
			o_min_gap <= 16'hFFFF;
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			o_ones <= o_ones + {15'h0000, i_pin};
			gap_q <= gap_q + 16'h0001;
			// the first edge after a clear only starts the gap, its run length is partial
			if (i_pin != last_q) begin
				if (seen_q && gap_q < o_min_gap)
					o_min_gap <= gap_q;
				gap_q <= 16'h0001;
				seen_q <= 1'b1;
			end
		end
		last_q <= i_pin;
	end
endmodule

/* File: tb/dmsd_monitor_top_tb_top.sv */
// self-checking bench for the monitor path: wishbone tasks and pin density checks
// assumes the rc meter model on the pin and a 100 MHz core clock
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module dmsd_monitor_top_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic lin = 1'b0;
	logic vld = 1'b1;
	logic clr = 1'b1;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rd;
	logic [15:0] cs = 16'h0000;
	logic [15:0] ls = 16'h0000;
	logic ack;
	logic pin;
	logic run;
	logic rdy;
	logic [31:0] q;
	logic [15:0] ones;
	logic [15:0] gap;
	int mismatches = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	dmsd_monitor_top dut (.i_core_clk(clk), .i_srst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(q),
		.i_linear_active(lin), .i_corr_sample(cs), .i_lin_sample(ls), .i_sample_valid(vld),
		.o_sample_ready(rdy), .o_clock_output_pin(pin), .o_cdr_run(run));
	dmsd_rc_meter meter (.i_core_clk(clk), .i_clear(clr), .i_pin(pin), .o_ones(ones), .o_min_gap(gap));
	task close_out;
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one classic cycle: hold everything until ack is sampled high, then release
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		rd = q;
		`CHK("wb_ack", 1'b1, ack)
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h00000000);
		`CHK(nm, e, rd)
	endtask
	// settle, then count ones over 4096 cycles; density is (x + 1) / 2 for a fraction x
	task window;
		repeat (256) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (4096) @(posedge clk);
	endtask
	task meas(input int e, input string nm);
		window();
		`CHK(nm, 1'b1, (int'(ones) > e - 64 && int'(ones) < e + 64))
	endtask
	// ready is registered in the fifo, so poll it under a bound
	task waitrdy(input logic want, input string nm);
		int n;
		n = 0;
		while (rdy !== want && n < 400) begin
			@(posedge clk);
			n++;
		end
		`CHK(nm, want, rdy)
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		$display("mismatch watchdog exp done got hang");
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdchk(dmsd_pkg::ADDR_TEST, dmsd_pkg::TEST_RESET, "test_reg");
		rdchk(dmsd_pkg::ADDR_OFS_GAIN, 32'h00000000, "ofs_gain_wo");
		rdchk(dmsd_pkg::ADDR_CLK_DIV, {16'h0000, dmsd_pkg::CDR_DIV_RESET, dmsd_pkg::DEMOD_DIV_RESET}, "div_reg");
		rdchk(4'h2, 32'h00000000, "unmapped");
		`CHK("cdr_run_slow", 1'b1, run)
		meas(0, "pin_off");
		// data-recovery clock raised above the demodulator clock for a cleaner stream
		wb(1'b1, dmsd_pkg::ADDR_CLK_DIV, 32'h00000408);
		repeat (2) @(posedge clk);
		`CHK("cdr_run_fast", 1'b0, run)
		cs <= 16'hC000;
		ls <= 16'h3000;
		wb(1'b1, dmsd_pkg::ADDR_TEST, 32'h0001C00C);
		meas(1024, "corr_raw");
		// offset 1024 is a quarter of full scale, half the measured if, gain shift 1
		wb(1'b1, dmsd_pkg::ADDR_OFS_GAIN, 32'h0C0001AD);
		lin <= 1'b1;
		// raw mode skips the offset but still applies the gain: 0.375 doubled to 0.75
		meas(3584, "lin_raw");
		wb(1'b1, dmsd_pkg::ADDR_TEST, 32'h0002800C);
		wb(1'b0, dmsd_pkg::ADDR_STATUS, 32'h00000000);
		`CHK("status_mode", 3'b110, rd[2:0])
		meas(2560, "lin_ofs");
		// wrong select code: offset 0 and gain 0 must not land
		wb(1'b1, dmsd_pkg::ADDR_OFS_GAIN, 32'h000001AC);
		meas(2560, "bad_select");
		wb(1'b1, dmsd_pkg::ADDR_CLK_DIV, 32'h00001008);
		repeat (2) @(posedge clk);
		`CHK("cdr_run_back", 1'b1, run)
		window();
		`CHK("min_gap", 1'b1, (gap >= 16'h0010))
		// fast pushes, very slow pops: the fifo fills and refuses
		wb(1'b1, dmsd_pkg::ADDR_CLK_DIV, 32'h0000FF01);
		waitrdy(1'b0, "fifo_full");
		wb(1'b1, dmsd_pkg::ADDR_TEST, dmsd_pkg::TEST_RESET);
		waitrdy(1'b1, "fifo_flush");
		meas(0, "pin_off_again");
		close_out();
	end
endmodule
